// File: dv/qdl_host_model.sv
// Purpose: Host controller model driving the three-wire serial load port.
// Assumes: Serial clock period 125 ns, parked low between frames apart from one stray pulse before each.
// Notes:   Records the daisy-chain output just ahead of each rising edge with the strobe low.

`timescale 1ns/1ps
`default_nettype none

module qdl_host_model (
  // Serial pins towards the loader
  output logic sclk_o,
  output logic select_load_n_o,
  output logic serial_in_o,
  // Daisy-chain output from the loader
  input wire logic serial_out_i
);
  logic [31:0] echo;

  // ----------------------------------------------------------------
  // Idle state and frame transfer
  // ----------------------------------------------------------------
  // Strobe idles high, clock parked low
  initial begin
    sclk_o = 1'b0;
    select_load_n_o = 1'b1;
    serial_in_o = 1'b0;
    echo = 32'h0000_0000;
  end

  // Shift the low nbits of word, MSB first, after one stray clock pulse with the strobe high
  task automatic send_frame(input int nbits, input logic [31:0] word);
    #20;  // Stray edge with the strobe high must leave the shift register alone
    sclk_o = 1'b1;
    #20;
    sclk_o = 1'b0;
    #13.7;  // Odd offset keeps the link unrelated to the system clock
    select_load_n_o = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      serial_in_o = word[i];
      #62.5;
      echo = {echo[30:0], serial_out_i};
      sclk_o = 1'b1;
      #62.5;
      sclk_o = 1'b0;
    end
    #62.5;
    select_load_n_o = 1'b1;
    serial_in_o = ~serial_in_o;  // Data is no longer held after the frame
  endtask
endmodule

`default_nettype wire

// File: dv/tb.sv
// Purpose: Self-checking bench for the quad converter serial loader.
// Assumes: Host model drives the link; both clear variants share inputs.
// Notes:   All scenarios share one expected register image, built up in turn.

`timescale 1ns/1ps
`default_nettype none

module tb;
  import qdl_pkg::*;

  logic clk_sys_i, rst_n_i, ce_i, async_clear_n_i;
  wire sclk, sel_n, serial_in, serial_out;
  logic [NUM_CH-1:0][CODE_W-1:0] dac, inp, dac_mid, e_dac, e_inp;
  logic [NUM_CH-1:0] pd, e_pd;
  logic done, rej;
  int err_count = 0;
  int num_checks = 0;

  // ----------------------------------------------------------------
  // Design, midscale variant and host
  // ----------------------------------------------------------------
  qdl_serial_loader i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .sclk_i(sclk), .select_load_n_i(sel_n), .serial_in_i(serial_in), .serial_out_o(serial_out),
    .async_clear_n_i(async_clear_n_i), .dac_code_o(dac), .input_code_o(inp),
    .power_down_o(pd), .cmd_done_o(done), .cmd_reject_o(rej));
  qdl_serial_loader #(.MIDSCALE_VARIANT(1'b1)) i_dut_mid (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .ce_i(ce_i), .sclk_i(sclk), .select_load_n_i(sel_n),
    .serial_in_i(serial_in), .serial_out_o(), .async_clear_n_i(async_clear_n_i),
    .dac_code_o(dac_mid), .input_code_o(), .power_down_o(), .cmd_done_o(),
    .cmd_reject_o());
  qdl_host_model i_host (.sclk_o(sclk), .select_load_n_o(sel_n), .serial_in_o(serial_in),
    .serial_out_i(serial_out));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_all;
    check("dac codes", e_dac, dac);
    check("input codes", e_inp, inp);
    check("power down", {60'h0, e_pd}, {60'h0, pd});
  endtask

  // Send one frame, then wait a bounded time for its outcome pulse
  task automatic frame(input int nbits, input logic [3:0] cmd, input logic [3:0] ch,
                       input logic [15:0] code, input logic exp_rej);
    logic got;
    got = 1'b0;
    i_host.send_frame(nbits, {8'ha5, cmd, ch, code});
    for (int k = 0; k < 20 && !got; k++) begin
      @(posedge clk_sys_i);
      #1;
      if (done === 1'b1 || rej === 1'b1) begin
        got = 1'b1;
        check("reject pulse", {63'h0, exp_rej}, {63'h0, rej});
      end
    end
    if (!got) begin
      check("outcome pulse", 64'h1, 64'h0);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_write_update;
    e_dac[0] = 16'h1234;
    e_inp[0] = 16'h1234;
    frame(24, CMD_WR_UPD, 4'h0, 16'h1234, 1'b0);
    cmp_all();
    e_dac[2] = 16'h2468;
    e_inp[2] = 16'h2468;
    frame(32, CMD_WR_UPD, 4'h2, 16'h2468, 1'b0);
    cmp_all();
    $display("test write_update done");
  endtask

  // Long frame with junk prefix; update ignores its own data word
  task automatic t_write_then_update;
    e_inp[1] = 16'habcd;
    frame(32, CMD_WRITE, 4'h1, 16'habcd, 1'b0);
    cmp_all();
    e_dac[1] = 16'habcd;
    frame(32, CMD_UPDATE, 4'h1, 16'hffff, 1'b0);
    cmp_all();
    $display("test write_then_update done");
  endtask

  task automatic t_power;
    e_pd[2] = 1'b1;
    frame(24, CMD_PDOWN, 4'h2, 16'h7777, 1'b0);
    cmp_all();
    e_pd = MASK_ALL;
    frame(24, CMD_PDOWN, CH_ALL, 16'h7777, 1'b0);
    cmp_all();
    e_inp[3] = 16'h5555;
    e_dac = e_inp;
    e_pd = MASK_NONE;
    frame(24, CMD_WR_UPD_ALL, CH_LAST, 16'h5555, 1'b0);
    cmp_all();
    frame(24, CMD_NOP, 4'h0, 16'hdead, 1'b0);
    cmp_all();
    $display("test power done");
  endtask

  // Deliberately breaks the host's code restriction
  task automatic t_reserved;
    frame(24, 4'h7, 4'h0, 16'h9999, 1'b1);
    frame(24, CMD_WR_UPD, 4'h5, 16'h9999, 1'b1);
    cmp_all();
    $display("test reserved done");
  endtask

  // Second full frame must push the first one out MSB first
  task automatic t_daisy;
    frame(32, CMD_NOP, CH_ALL, 16'hc3a5, 1'b0);
    frame(32, CMD_NOP, CH_ALL, 16'h0f0f, 1'b0);
    check("daisy echo", {32'h0, 32'ha5ff_c3a5}, {32'h0, i_host.echo});
    check("output driven", 64'h1, {63'h0, (serial_out === 1'b0 || serial_out === 1'b1)});
    $display("test daisy done");
  endtask

  // Checked before any further edge, so only an async clear passes
  task automatic t_clear;
    @(posedge clk_sys_i);
    async_clear_n_i <= 1'b0;
    #1;
    e_dac = '0;
    e_inp = '0;
    cmp_all();
    check("midscale clear", {4{CODE_MID}}, dac_mid);
    @(posedge clk_sys_i);
    async_clear_n_i <= 1'b1;
    $display("test clear done");
  endtask

  // ----------------------------------------------------------------
  // Clock, main sequence, watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    async_clear_n_i = 1'b1;
    e_dac = '0;
    e_inp = '0;
    e_pd = MASK_NONE;
    // Power-on clear pulse; the link domain has no other reset
    @(posedge clk_sys_i);
    async_clear_n_i <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    async_clear_n_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    t_write_update();
    t_write_then_update();
    t_power();
    t_reserved();
    t_daisy();
    t_clear();
    summarize();
  end

  // Twelve frames of about 3 to 4 us each; generous margin
  initial begin
    #400000;
    err_count++;
    summarize();
  end
endmodule

`default_nettype wire

// File: logic/qdl_link_shift.sv
// Purpose: Link-side 32-bit input shift register and daisy-chain output.
// Assumes: Serial clock may also pulse outside frames; strobe is timed to it.
// Notes:   Only clear resets this domain, since the serial clock may stop.

`timescale 1ns/1ps
`default_nettype none

module qdl_link_shift
  import qdl_pkg::*;
(
  // Link clock and clear
  input wire logic sclk_i,
  input wire logic async_clear_n_i,
  // Serial pins
  input wire logic select_load_n_i,
  input wire logic serial_in_i,
  output logic serial_out_o,
  // Shifted word towards the system domain
  output logic [qdl_pkg::FRAME_W-1:0] shift_word_o
);

  // ----------------------------------------------------------------
  // Input shift register
  // ----------------------------------------------------------------
  // Edges are ignored while the strobe is high
  always_ff @(posedge sclk_i or negedge async_clear_n_i) begin
    if (!async_clear_n_i) begin
      shift_word_o <= FRAME_RST;
    end else if (!select_load_n_i) begin
      shift_word_o <= {shift_word_o[FRAME_W-2:0], serial_in_i};
    end
  end

  // ----------------------------------------------------------------
  // Daisy-chain output
  // ----------------------------------------------------------------
  // Far end leaves on the falling edge, half a period of hold downstream
  always_ff @(negedge sclk_i or negedge async_clear_n_i) begin
    if (!async_clear_n_i) begin
      serial_out_o <= 1'b0;
    end else begin
      serial_out_o <= shift_word_o[FRAME_W-1];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_shift_in;
    @(posedge sclk_i) disable iff (!async_clear_n_i)
    !select_load_n_i |=> shift_word_o == {$past(shift_word_o[FRAME_W-2:0]), $past(serial_in_i)};
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("shift input lost");

  property p_hold_high;
    @(posedge sclk_i) disable iff (!async_clear_n_i)
    select_load_n_i |=> $stable(shift_word_o);
  endproperty
  a_hold_high: assert property (p_hold_high) else $error("shift while deselected");

  property p_tail_out;
    @(posedge sclk_i) disable iff (!async_clear_n_i)
    !select_load_n_i ##1 !select_load_n_i |-> serial_out_o == shift_word_o[FRAME_W-1];
  endproperty
  a_tail_out: assert property (p_tail_out) else $error("serial out wrong bit");

endmodule

`default_nettype wire

// File: logic/qdl_pkg.sv
// Purpose: Shared constants and types for the quad converter serial loader.
// Assumes: 32-bit shift register, 16-bit codes, four channels.
// Notes:   Frame fields are counted from the last bit shifted in (bit 0).

package qdl_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_CH = 4;
  localparam int CODE_W = 16;
  localparam int FRAME_W = 32;
  localparam int FIELD_W = 4;

  // ----------------------------------------------------------------
  // Field positions inside the low 24 bits of the shift register
  // ----------------------------------------------------------------
  localparam int CMD_HI = 23;
  localparam int CMD_LO = 20;
  localparam int CH_HI = 19;
  localparam int CH_LO = 16;
  localparam int DATA_HI = 15;
  localparam int DATA_LO = 0;

  // ----------------------------------------------------------------
  // Values after reset and clear, and the all-channel mask
  // ----------------------------------------------------------------
  localparam logic [CODE_W-1:0] CODE_ZERO = 16'h0000;
  localparam logic [CODE_W-1:0] CODE_MID = 16'h8000;
  localparam logic [FRAME_W-1:0] FRAME_RST = 32'h0000_0000;
  localparam logic [NUM_CH-1:0] MASK_NONE = 4'h0;
  localparam logic [NUM_CH-1:0] MASK_ALL = 4'hf;

  // ----------------------------------------------------------------
  // Command and channel codes
  // ----------------------------------------------------------------
  typedef enum logic [FIELD_W-1:0] {
    CMD_WRITE = 4'h0,
    CMD_UPDATE = 4'h1,
    CMD_WR_UPD_ALL = 4'h2,
    CMD_WR_UPD = 4'h3,
    CMD_PDOWN = 4'h4,
    CMD_NOP = 4'hf
  } qdl_cmd_t;

  localparam logic [FIELD_W-1:0] CH_ALL = 4'hf;
  localparam logic [FIELD_W-1:0] CH_LAST = 4'h3;

endpackage

// File: logic/qdl_serial_loader.sv
// Purpose: Serial load port and register control of a four-channel
//          voltage-output converter, with daisy-chain output.
// Assumes: Serial clock is its own domain; strobe stays high at least
//          four system cycles so the captured word is still stable.
// Notes:   Codes and power states leave on flip-flops; clear is async.
//
// Function
// - While the strobe is low every rising serial clock shifts one input bit in.
// - A rising strobe stops shifting and runs the command in the shift register.
// - Input bits are valid at and sampled on the rising serial clock edge.
// - Frames of 24 and of 32 bits both execute correctly.
// - The serial output shows the far end, 32 rising edges late, on falling edges.
// - The serial output is always driven, even with the strobe high.
// - A low clear forces the input and converter registers to zero code at once, without a clock.
// - On the midscale variant a low clear loads midscale code instead.
// - A frame is command, channel, then a 16-bit code MSB first, 8 bits before ignored.
// - Commands are write, update, write-and-update-all, write-and-update, power down, nop.
// - An update copies the input register to the converter register and powers up.

`timescale 1ns/1ps
`default_nettype none

module qdl_serial_loader
  import qdl_pkg::*;
#(
  parameter logic MIDSCALE_VARIANT = 1'b0
) (
  // System clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Serial link from the host
  input wire logic sclk_i,
  input wire logic select_load_n_i,
  input wire logic serial_in_i,
  output logic serial_out_o,
  // Asynchronous clear pin
  input wire logic async_clear_n_i,
  // Channel state towards the converters
  output logic [qdl_pkg::NUM_CH-1:0][qdl_pkg::CODE_W-1:0] dac_code_o,
  output logic [qdl_pkg::NUM_CH-1:0][qdl_pkg::CODE_W-1:0] input_code_o,
  output logic [qdl_pkg::NUM_CH-1:0] power_down_o,
  // Command outcome pulses
  output logic cmd_done_o,
  output logic cmd_reject_o
);

  import qdl_pkg::*;

  // ----------------------------------------------------------------
  // Local constants and functions
  // ----------------------------------------------------------------
  localparam logic [CODE_W-1:0] CLEAR_CODE = MIDSCALE_VARIANT ? CODE_MID : CODE_ZERO;

  // One-hot channel select, all ones for CH_ALL; zero for a reserved channel code
  function automatic logic [NUM_CH-1:0] ch_mask(input logic [FIELD_W-1:0] ch);
    logic [NUM_CH-1:0] m;
    m = MASK_NONE;
    if (ch == CH_ALL) begin
      m = MASK_ALL;
    end else if (ch <= CH_LAST) begin
      m[ch[1:0]] = 1'b1;
    end
    return m;
  endfunction

  // True for a listed command code
  function automatic logic cmd_known(input logic [FIELD_W-1:0] cmd);
    return (cmd == CMD_WRITE) || (cmd == CMD_UPDATE) || (cmd == CMD_WR_UPD_ALL) ||
           (cmd == CMD_WR_UPD) || (cmd == CMD_PDOWN) || (cmd == CMD_NOP);
  endfunction

  // ----------------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------------
  logic [FRAME_W-1:0] shift_word;

  qdl_link_shift u_link (
    .sclk_i(sclk_i),
    .async_clear_n_i(async_clear_n_i),
    .select_load_n_i(select_load_n_i),
    .serial_in_i(serial_in_i),
    .serial_out_o(serial_out_o),
    .shift_word_o(shift_word)
  );

  // ----------------------------------------------------------------
  // Strobe crossing and frame capture
  // ----------------------------------------------------------------
  logic strobe_s;
  logic strobe_d;
  logic strobe_rise;
  logic exec_q;
  logic [FRAME_W-1:0] frame_q;

  qdl_sync2 #(
    .RST_VAL(1'b1)
  ) u_strobe_sync (
    .clk_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .d_i(select_load_n_i),
    .q_o(strobe_s)
  );

  // Rising strobe seen after synchronising
  assign strobe_rise = strobe_s & ~strobe_d;

  // Edge history register
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      strobe_d <= 1'b1;
    end else if (ce_i) begin
      strobe_d <= strobe_s;
    end
  end

  // Word is quiet while the strobe is high, so the strobe qualifies it
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      frame_q <= FRAME_RST;
      exec_q <= 1'b0;
    end else if (ce_i) begin
      exec_q <= strobe_rise;
      if (strobe_rise) begin
        frame_q <= shift_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // Last 24 bits hold the command, so leading bits of a long frame drop out
  wire [FIELD_W-1:0] cmd_f = frame_q[CMD_HI:CMD_LO];
  wire [FIELD_W-1:0] ch_f = frame_q[CH_HI:CH_LO];
  wire [CODE_W-1:0] data_f = frame_q[DATA_HI:DATA_LO];
  wire [NUM_CH-1:0] sel = ch_mask(ch_f);
  wire legal = exec_q & cmd_known(cmd_f) & (|sel);
  wire is_wr = (cmd_f == CMD_WRITE) | (cmd_f == CMD_WR_UPD_ALL) | (cmd_f == CMD_WR_UPD);
  wire is_upd = (cmd_f == CMD_UPDATE) | (cmd_f == CMD_WR_UPD);
  wire is_upd_all = (cmd_f == CMD_WR_UPD_ALL);
  wire is_pd = (cmd_f == CMD_PDOWN);

  // Masks per channel; all zero unless the frame is legal
  wire [NUM_CH-1:0] wr_mask = (legal & is_wr) ? sel : MASK_NONE;
  wire [NUM_CH-1:0] upd_mask = !legal ? MASK_NONE :
                               is_upd_all ? MASK_ALL :
                               is_upd ? sel : MASK_NONE;
  wire [NUM_CH-1:0] pd_mask = (legal & is_pd) ? sel : MASK_NONE;

  // ----------------------------------------------------------------
  // Next converter codes
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0][CODE_W-1:0] next_dac;

  // A channel written in the same frame takes the new word directly
  for (genvar g = 0; g < NUM_CH; g++) begin : g_next
    assign next_dac[g] = wr_mask[g] ? data_f : input_code_o[g];
  end

  // ----------------------------------------------------------------
  // Input and converter registers
  // ----------------------------------------------------------------
  // Clear acts without a clock and overrides enable and reset
  always_ff @(posedge clk_sys_i or negedge async_clear_n_i) begin
    if (!async_clear_n_i) begin
      input_code_o <= {NUM_CH{CLEAR_CODE}};
      dac_code_o <= {NUM_CH{CLEAR_CODE}};
    end else if (!rst_n_i) begin
      input_code_o <= {NUM_CH{CLEAR_CODE}};
      dac_code_o <= {NUM_CH{CLEAR_CODE}};
    end else if (ce_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (wr_mask[i]) begin
          input_code_o[i] <= data_f;
        end
        if (upd_mask[i]) begin
          dac_code_o[i] <= next_dac[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Power state and outcome pulses
  // ----------------------------------------------------------------
  // Power state survives clear; register contents are never disturbed
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      power_down_o <= MASK_NONE;
      cmd_done_o <= 1'b0;
      cmd_reject_o <= 1'b0;
    end else if (ce_i) begin
      power_down_o <= (power_down_o & ~upd_mask) | pd_mask;
      cmd_done_o <= legal;
      cmd_reject_o <= exec_q & ~legal;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_exec_follows;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    ce_i && strobe_rise |=> exec_q && frame_q == $past(shift_word);
  endproperty
  a_exec_follows: assert property (p_exec_follows) else $error("frame not captured");

  property p_write_one;
    @(posedge clk_sys_i) disable iff (!rst_n_i || !async_clear_n_i)
    ce_i && legal && cmd_f == CMD_WRITE && ch_f <= CH_LAST
      |=> input_code_o[$past(ch_f[1:0])] == $past(data_f) && $stable(dac_code_o);
  endproperty
  a_write_one: assert property (p_write_one) else $error("write failed");

  property p_update_one;
    @(posedge clk_sys_i) disable iff (!rst_n_i || !async_clear_n_i)
    ce_i && legal && cmd_f == CMD_UPDATE && ch_f == 4'h1
      |=> dac_code_o[1] == $past(input_code_o[1]) && !power_down_o[1];
  endproperty
  a_update_one: assert property (p_update_one) else $error("update failed");

  property p_wr_upd_all;
    @(posedge clk_sys_i) disable iff (!rst_n_i || !async_clear_n_i)
    ce_i && legal && cmd_f == CMD_WR_UPD_ALL && ch_f == CH_LAST
      |=> dac_code_o[3] == $past(data_f) && dac_code_o[0] == $past(input_code_o[0])
          && power_down_o == MASK_NONE;
  endproperty
  a_wr_upd_all: assert property (p_wr_upd_all) else $error("update all failed");

  property p_pdown_all;
    @(posedge clk_sys_i) disable iff (!rst_n_i || !async_clear_n_i)
    ce_i && legal && cmd_f == CMD_PDOWN && ch_f == CH_ALL
      |=> power_down_o == MASK_ALL && $stable(dac_code_o) && $stable(input_code_o);
  endproperty
  a_pdown_all: assert property (p_pdown_all) else $error("power down failed");

  property p_reserved;
    @(posedge clk_sys_i) disable iff (!rst_n_i || !async_clear_n_i)
    ce_i && exec_q && !legal
      |=> $stable(dac_code_o) && $stable(input_code_o) && $stable(power_down_o) && cmd_reject_o;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code acted");

  property p_clear_zero;
    @(posedge clk_sys_i)
    !MIDSCALE_VARIANT && !async_clear_n_i |-> dac_code_o == '0 && input_code_o == '0;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("clear not zero");

  property p_clear_mid;
    @(posedge clk_sys_i)
    MIDSCALE_VARIANT && !async_clear_n_i |-> dac_code_o == {NUM_CH{CODE_MID}};
  endproperty
  a_clear_mid: assert property (p_clear_mid) else $error("clear not midscale");

  property p_long_frame;
    @(posedge clk_sys_i) disable iff (!rst_n_i || !async_clear_n_i)
    ce_i && legal && cmd_f == CMD_WR_UPD && ch_f == 4'h2
      |=> dac_code_o[2] == $past(data_f) && input_code_o[2] == $past(data_f) && cmd_done_o;
  endproperty
  a_long_frame: assert property (p_long_frame) else $error("frame length mishandled");

  // Short frame carries the same fields in the same places
  property p_short_frame;
    @(posedge clk_sys_i) disable iff (!rst_n_i || !async_clear_n_i)
    ce_i && legal && cmd_f == CMD_WR_UPD && ch_f == 4'h0
      |=> dac_code_o[0] == $past(data_f) && input_code_o[0] == $past(data_f)
          && !power_down_o[0];
  endproperty
  a_short_frame: assert property (p_short_frame) else $error("short frame mishandled");

  property p_pdown_one;
    @(posedge clk_sys_i) disable iff (!rst_n_i || !async_clear_n_i)
    ce_i && legal && cmd_f == CMD_PDOWN && ch_f == 4'h2
      |=> power_down_o[2] && $stable(dac_code_o) && $stable(input_code_o);
  endproperty
  a_pdown_one: assert property (p_pdown_one) else $error("channel power down failed");

  property p_nop_still;
    @(posedge clk_sys_i) disable iff (!rst_n_i || !async_clear_n_i)
    ce_i && legal && cmd_f == CMD_NOP
      |=> $stable(dac_code_o) && $stable(input_code_o) && $stable(power_down_o)
          && cmd_done_o;
  endproperty
  a_nop_still: assert property (p_nop_still) else $error("no-operation acted");

  property p_bad_cmd;
    @(posedge clk_sys_i) disable iff (!rst_n_i || !async_clear_n_i)
    ce_i && exec_q && !cmd_known(cmd_f) |=> cmd_reject_o && !cmd_done_o;
  endproperty
  a_bad_cmd: assert property (p_bad_cmd) else $error("reserved command accepted");

  // One execution per strobe rise, never a stretched pulse
  property p_done_pulse;
    @(posedge clk_sys_i) disable iff (!rst_n_i || !async_clear_n_i)
    cmd_done_o |=> !cmd_done_o;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done pulse stretched");

endmodule

`default_nettype wire

// File: logic/qdl_sync2.sv
// Purpose: Two-stage synchroniser for a level entering the system clock.
// Assumes: Input is a slow level, held longer than three system cycles.
// Notes:   Stage one is read only by stage two.

`timescale 1ns/1ps
`default_nettype none

module qdl_sync2 #(
  parameter logic RST_VAL = 1'b1
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Level in and out
  input wire logic d_i,
  output logic q_o
);

  logic meta;

  // ----------------------------------------------------------------
  // Synchroniser stages
  // ----------------------------------------------------------------
  // Frozen with the rest of the domain while the enable is low
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta <= RST_VAL;
      q_o <= RST_VAL;
    end else if (ce_i) begin
      meta <= d_i;
      q_o <= meta;
    end
  end

endmodule

`default_nettype wire
